// File: verilog/tcp_pkg.sv
package tcp_pkg;

  localparam int          CNT_W          = 16;
  localparam int          NUM_CHAN       = 3;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;

  // Counter operating modes
  localparam logic [1:0]  TMODE_SUSPEND  = 2'h0;
  localparam logic [1:0]  TMODE_FREE     = 2'h1;
  localparam logic [1:0]  TMODE_MODULO   = 2'h2;
  localparam logic [1:0]  TMODE_UPDOWN   = 2'h3;

  // Compare actions
  localparam logic [2:0]  ACT_SET        = 3'h0;
  localparam logic [2:0]  ACT_CLEAR      = 3'h1;
  localparam logic [2:0]  ACT_TOGGLE     = 3'h2;
  localparam logic [2:0]  ACT_SET_UP     = 3'h3;
  localparam logic [2:0]  ACT_CLR_UP     = 3'h4;
  localparam logic [2:0]  ACT_CLR_PER    = 3'h5;
  localparam logic [2:0]  ACT_SET_PER    = 3'h6;
  localparam logic [2:0]  ACT_SPECIAL    = 3'h7;
  localparam logic [2:0]  ACT_LAST_IMM   = ACT_TOGGLE;
  localparam logic [2:0]  ACT_FIRST_CH0X = ACT_SET_PER;

  // Shared interrupt vector number
  localparam logic [4:0]  IRQ_VECTOR     = 5'h09;

  // Flag vector positions
  localparam int          FLG_OVF        = 0;
  localparam int          FLG_CH0        = 1;

  // Modulator
  localparam logic [15:0] SAMPLE_MASK    = 16'hFFFC;
  localparam int          CAP_ZOH_BIT    = 1;
  localparam int          CAP_SHAPE_BIT  = 0;
  localparam logic [2:0]  DSM_PH_FAST    = 3'h3;
  localparam logic [2:0]  DSM_PH_SLOW    = 3'h7;
  localparam int          DSM_SH_FAST    = 2;
  localparam int          DSM_SH_SLOW    = 3;
  localparam int          DSM_FRAC       = 16;
  localparam int          DSM_ACC_W      = 24;
  localparam logic [23:0] DSM_FB_POS     = 24'h008000;
  localparam logic [23:0] DSM_FB_NEG     = 24'hFF8000;

  typedef enum logic [1:0] {
    TCP_DSM_IDLE = 2'b01,
    TCP_DSM_RUN  = 2'b10
  } tcp_dsm_state_t;

endpackage

// File: verilog/tcp_dsm.sv
`timescale 1ns/1ps
module tcp_dsm #(
  parameter int W = 16
) (
  input  wire logic         i_clk,         // System clock
  input  wire logic         i_reset,       // Async reset, active high
  input  wire logic         i_enable,      // Modulator enabled
  input  wire logic         i_tick,        // Undivided timer tick pulse
  input  wire logic         i_rate_slow,   // 1: 1/8 tick rate, 0: 1/4
  input  wire logic         i_zoh,         // Zeroth-order hold
  input  wire logic         i_shaper,      // Edge shaper enable
  input  wire logic [W-1:0] i_sample,      // Signed sample
  input  wire logic         i_sample_load, // New sample period
  input  wire logic [W-1:0] i_period,      // Sample period in ticks
  output logic              o_bit          // Modulator output
);

  localparam int FW = W + tcp_pkg::DSM_FRAC;
  localparam int AW = tcp_pkg::DSM_ACC_W;

  tcp_pkg::tcp_dsm_state_t state_q;
  logic [2:0]              ph_q;
  logic [2:0]              ph_last;
  logic [2:0]              ph_next;
  logic                    step;
  logic signed [FW-1:0]    cur_q;
  logic signed [FW-1:0]    inc_q;
  logic signed [FW-1:0]    delta;
  logic [W-1:0]            steps;
  logic [4:0]              shift;
  logic signed [W-1:0]     smp;
  logic signed [W-1:0]     x;
  logic signed [AW-1:0]    fb;
  logic signed [AW-1:0]    int1_q;
  logic signed [AW-1:0]    int2_q;
  logic signed [AW-1:0]    int1_d;
  logic signed [AW-1:0]    int2_d;
  logic                    bit_q;
  logic                    bit_now;

  function automatic logic [4:0] ceil_log2(input logic [W-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 0; k < W; k++) begin
      if ((v >> k) > 1) begin
        r = 5'(k + 1);
      end
    end
    return r;
  endfunction

  assign smp     = i_sample & tcp_pkg::SAMPLE_MASK;
  assign ph_last = i_rate_slow ? tcp_pkg::DSM_PH_SLOW
                               : tcp_pkg::DSM_PH_FAST;
  assign ph_next = (ph_q == ph_last) ? 3'h0 : ph_q + 3'h1;
  assign step    = (state_q == tcp_pkg::TCP_DSM_RUN) && i_tick
                   && (ph_q == ph_last);
  // Shift gain stands in for a divider: a little overshoot, no divider
  assign steps   = i_rate_slow ? (i_period >> tcp_pkg::DSM_SH_SLOW)
                               : (i_period >> tcp_pkg::DSM_SH_FAST);
  assign shift   = ceil_log2(steps);
  assign delta   = ($signed({smp, {tcp_pkg::DSM_FRAC{1'b0}}}) - cur_q);
  assign x       = cur_q[FW-1 -: W];
  assign fb      = bit_q ? $signed(tcp_pkg::DSM_FB_POS)
                         : $signed(tcp_pkg::DSM_FB_NEG);
  assign int1_d  = int1_q + AW'(x) - fb;
  assign int2_d  = int2_q + int1_d - fb;
  assign bit_now = step ? ~int2_d[AW-1] : bit_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= tcp_pkg::TCP_DSM_IDLE;
    end else begin
      state_q <= i_enable ? tcp_pkg::TCP_DSM_RUN : tcp_pkg::TCP_DSM_IDLE;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ph_q <= 3'h0;
    end else if (state_q != tcp_pkg::TCP_DSM_RUN) begin
      ph_q <= 3'h0;
    end else if (i_tick) begin
      ph_q <= ph_next;
    end
  end

  // First-order interpolator with gain compensation
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cur_q <= '0;
      inc_q <= '0;
    end else if (state_q != tcp_pkg::TCP_DSM_RUN) begin
      cur_q <= '0;
      inc_q <= '0;
    end else if (i_sample_load) begin
      inc_q <= delta >>> shift;
    end else if (step) begin
      cur_q <= i_zoh ? $signed({smp, {tcp_pkg::DSM_FRAC{1'b0}}})
                     : cur_q + inc_q;
    end
  end

  // Second-order loop
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      int1_q <= '0;
      int2_q <= '0;
      bit_q  <= 1'b0;
    end else if (state_q != tcp_pkg::TCP_DSM_RUN) begin
      int1_q <= '0;
      int2_q <= '0;
      bit_q  <= 1'b0;
    end else if (step) begin
      int1_q <= int1_d;
      int2_q <= int2_d;
      bit_q  <= ~int2_d[AW-1];
    end
  end

  // Shaper: high slot at bit start, low slot at bit end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bit <= 1'b0;
    end else if (state_q != tcp_pkg::TCP_DSM_RUN) begin
      o_bit <= 1'b0;
    end else if (i_tick) begin
      if (i_shaper && ph_next == 3'h0) begin
        o_bit <= 1'b1;
      end else if (i_shaper && ph_next == ph_last) begin
        o_bit <= 1'b0;
      end else begin
        o_bit <= bit_now;
      end
    end
  end

endmodule // tcp_dsm

// File: verilog/tcp_timer.sv
`timescale 1ns/1ps
module tcp_timer #(
  parameter int NCH = tcp_pkg::NUM_CHAN,
  parameter int CW  = tcp_pkg::CNT_W
) (
  input  wire logic           i_clk,                // System clock
  input  wire logic           i_reset,              // Async reset
  input  wire logic [1:0]     i_timer_mode,         // Counter mode
  input  wire logic [CW-1:0]  i_count,              // Counter value
  input  wire logic           i_count_step,         // Counter advanced
  input  wire logic           i_count_down,         // Last step was down
  input  wire logic           i_tick,               // Undivided tick
  input  wire logic [7:0]     i_wr_data,            // Byte written
  input  wire logic [NCH-1:0] i_cmp_low_wr,         // Low byte write
  input  wire logic [NCH-1:0] i_cmp_high_wr,        // High byte write
  input  wire logic [3*NCH-1:0] i_chan_cmp_action,  // Action per chan
  input  wire logic [NCH-1:0] i_chan_mode,          // 1: compare mode
  input  wire logic [NCH-1:0] i_chan_irq_mask,      // Channel masks
  input  wire logic           i_overflow_irq_mask,  // Overflow mask
  input  wire logic [1:0]     i_capture_sel_field_1, // Chan 1 capture
  input  wire logic [NCH-1:0] i_capture_evt,        // Capture pulses
  input  wire logic           i_global_timer_irq_enable, // Global en
  input  wire logic [3:0]     i_flag_clr,           // Clear ovf,ch0..2
  input  wire logic           i_cpu_irq_flag_clr,   // Clear CPU flag
  output logic [NCH-1:0]      o_chan_out,           // Channel pins
  output logic [CW*NCH-1:0]   o_chan_cmp_value,     // Active values
  output logic [CW-1:0]       o_period_value,       // Channel 0 value
  output logic                o_overflow_flag,      // Overflow flag
  output logic                o_chan0_event_flag,   // Channel 0 flag
  output logic                o_chan1_event_flag,   // Channel 1 flag
  output logic                o_chan2_event_flag,   // Channel 2 flag
  output logic                o_cpu_timer_irq_flag, // CPU level flag
  output logic                o_irq_req,            // Request pulse
  output logic [4:0]          o_irq_vector,         // Vector number
  output logic                o_dma_trig_chan0,     // DMA trigger 0
  output logic                o_dma_trig_chan1,     // DMA trigger 1
  output logic                o_dma_trig_chan2,     // DMA trigger 2
  output logic                o_dsm_active          // Modulator runs
);

  logic            running;
  logic            at_zero;
  logic            at_period;
  logic            updown;
  logic            ovf_evt;
  logic [NCH-1:0]  match;
  logic [NCH-1:0]  chan_evt;
  logic [NCH-1:0]  pin_d;
  logic [CW-1:0]   cmp_val [NCH];
  logic [3:0]      evt;
  logic [3:0]      mask;
  logic [3:0]      masked;
  logic [3:0]      flag_q;
  logic [3:0]      mask_prev_q;
  logic            cpu_flag_q;
  logic            irq_q;
  logic [NCH-1:0]  dma_q;
  logic [NCH-1:0]  pin_q;
  logic            dsm_en;
  logic            dsm_bit;

  assign running = i_timer_mode != tcp_pkg::TMODE_SUSPEND;
  assign updown  = i_timer_mode == tcp_pkg::TMODE_UPDOWN;
  assign at_zero = running && i_count_step && i_count == tcp_pkg::CNT_ZERO;

  always_comb begin
    unique case (i_timer_mode)
      tcp_pkg::TMODE_FREE:    at_period = i_count == tcp_pkg::CNT_MAX;
      tcp_pkg::TMODE_MODULO,
      tcp_pkg::TMODE_UPDOWN:  at_period = i_count == cmp_val[0];
      default:                at_period = 1'b0;
    endcase
    at_period = at_period && running && i_count_step;
  end

  // Terminal count, or turnaround at zero in up/down
  always_comb begin
    if (updown) begin
      ovf_evt = at_zero && i_count_down;
    end else begin
      ovf_evt = at_period;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      logic [7:0]    low_buf_q;
      logic [CW-1:0] cmp_q;
      logic [CW-1:0] pend_q;
      logic          pend_vld_q;
      logic [2:0]    act;
      logic          act_ok;
      logic          out_q;

      assign act    = i_chan_cmp_action[3*g +: 3];
      assign act_ok = (g != 0) || (act < tcp_pkg::ACT_FIRST_CH0X);
      assign match[g] = running && i_count_step && i_chan_mode[g]
                        && i_count == cmp_q;
      assign cmp_val[g] = cmp_q;
      assign o_chan_cmp_value[CW*g +: CW] = cmp_q;
      assign pin_d[g] = out_q;

      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          low_buf_q <= 8'h00;
        end else if (i_cmp_low_wr[g]) begin
          low_buf_q <= i_wr_data;
        end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          cmp_q      <= tcp_pkg::CNT_ZERO;
          pend_q     <= tcp_pkg::CNT_ZERO;
          pend_vld_q <= 1'b0;
        end else if (i_cmp_high_wr[g]) begin
          if (act <= tcp_pkg::ACT_LAST_IMM) begin
            cmp_q      <= {i_wr_data, low_buf_q};
            pend_vld_q <= 1'b0;
          end else begin
            pend_q     <= {i_wr_data, low_buf_q};
            pend_vld_q <= 1'b1;
          end
        end else if (pend_vld_q && at_zero) begin
          cmp_q      <= pend_q;
          pend_vld_q <= 1'b0;
        end
      end

      // Registered pin: edges only on the clock, never glitching
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          out_q <= 1'b0;
        end else if (act_ok && i_chan_mode[g]) begin
          unique case (act)
            tcp_pkg::ACT_SET:    if (match[g]) out_q <= 1'b1;
            tcp_pkg::ACT_CLEAR:  if (match[g]) out_q <= 1'b0;
            tcp_pkg::ACT_TOGGLE: if (match[g]) out_q <= ~out_q;
            tcp_pkg::ACT_SET_UP: begin
              if (updown) begin
                if (match[g]) out_q <= ~i_count_down;
              end else if (match[g]) begin
                out_q <= 1'b1;
              end else if (at_zero) begin
                out_q <= 1'b0;
              end
            end
            tcp_pkg::ACT_CLR_UP: begin
              if (updown) begin
                if (match[g]) out_q <= i_count_down;
              end else if (match[g]) begin
                out_q <= 1'b0;
              end else if (at_zero) begin
                out_q <= 1'b1;
              end
            end
            tcp_pkg::ACT_CLR_PER: begin
              if (match[g]) begin
                out_q <= 1'b0;
              end else if (at_period) begin
                out_q <= 1'b1;
              end
            end
            tcp_pkg::ACT_SET_PER: begin
              if (match[g]) begin
                out_q <= 1'b1;
              end else if (at_period) begin
                out_q <= 1'b0;
              end
            end
            tcp_pkg::ACT_SPECIAL: out_q <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Channel 1 action 111 in compare mode hands the pin to the modulator
  assign dsm_en = i_chan_mode[1]
                  && i_chan_cmp_action[5:3] == tcp_pkg::ACT_SPECIAL;

  tcp_dsm #(
    .W (CW)
  ) u_dsm (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_enable      (dsm_en),
    .i_tick        (i_tick),
    .i_rate_slow   (i_chan_mode[1]),
    .i_zoh         (i_capture_sel_field_1[tcp_pkg::CAP_ZOH_BIT]),
    .i_shaper      (i_capture_sel_field_1[tcp_pkg::CAP_SHAPE_BIT]),
    .i_sample      (cmp_val[1]),
    .i_sample_load (at_zero),
    .i_period      (cmp_val[0]),
    .o_bit         (dsm_bit)
  );

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_q <= '0;
    end else begin
      pin_q    <= pin_d;
      pin_q[1] <= dsm_en ? dsm_bit : pin_d[1];
    end
  end

  // Channel events: capture, compare, or zero for chan 0 in up/down
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (!i_chan_mode[c]) begin
        chan_evt[c] = i_capture_evt[c] && running;
      end else if (c == 0 && updown) begin
        chan_evt[c] = ovf_evt;
      end else begin
        chan_evt[c] = match[c];
      end
    end
  end

  assign evt    = {chan_evt, ovf_evt};
  assign mask   = {i_chan_irq_mask, i_overflow_irq_mask};
  assign masked = evt & mask;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= (flag_q & ~i_flag_clr) | evt;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cpu_flag_q <= 1'b0;
    end else begin
      cpu_flag_q <= (cpu_flag_q && !i_cpu_irq_flag_clr) || |masked;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mask_prev_q <= 4'h0;
      irq_q       <= 1'b0;
    end else begin
      mask_prev_q <= mask;
      irq_q       <= i_global_timer_irq_enable
                     && |(masked | (mask & ~mask_prev_q & flag_q));
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dma_q <= '0;
    end else begin
      dma_q <= match;
    end
  end

  assign o_chan_out           = pin_q;
  assign o_period_value       = cmp_val[0];
  assign o_overflow_flag      = flag_q[tcp_pkg::FLG_OVF];
  assign o_chan0_event_flag   = flag_q[tcp_pkg::FLG_CH0];
  assign o_chan1_event_flag   = flag_q[tcp_pkg::FLG_CH0 + 1];
  assign o_chan2_event_flag   = flag_q[tcp_pkg::FLG_CH0 + 2];
  assign o_cpu_timer_irq_flag = cpu_flag_q;
  assign o_irq_req            = irq_q;
  assign o_irq_vector         = tcp_pkg::IRQ_VECTOR;
  assign o_dma_trig_chan0     = dma_q[0];
  assign o_dma_trig_chan1     = dma_q[1];
  assign o_dma_trig_chan2     = dma_q[2];
  assign o_dsm_active         = dsm_en;

endmodule // tcp_timer

// File: dv/tcp_cnt_model.sv
`timescale 1ns/1ps
module tcp_cnt_model (
  input  wire logic        i_clk,    // System clock
  input  wire logic        i_reset,  // Async reset
  input  wire logic [1:0]  i_mode,   // Counter mode
  input  wire logic [15:0] i_period, // Terminal count
  input  wire logic        i_clear,  // Counter clear
  output logic [15:0]      o_count,  // Counter value
  output logic             o_step,   // Fresh count pulse
  output logic             o_down,   // Counting down
  output logic             o_tick    // Timer tick
);
  logic [15:0] cnt_q;
  logic        step_q;
  logic        down_q;
  logic        tick_q;

  // Tick every second cycle; prescaler fixed at 1
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q  <= 16'h0000;
      step_q <= 1'b0;
      down_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= ~tick_q;
      step_q <= 1'b0;
      if (i_clear) begin
        cnt_q  <= 16'h0000;
        down_q <= 1'b0;
      end else if (tick_q && i_mode != 2'h0) begin
        step_q <= 1'b1;
        if (i_mode == 2'h1) begin
          cnt_q <= cnt_q + 16'h0001;
        end else if (i_mode == 2'h2) begin
          down_q <= 1'b0;
          cnt_q  <= (cnt_q == i_period) ? 16'h0000 : cnt_q + 16'h0001;
        end else if (!down_q && cnt_q == i_period) begin
          down_q <= 1'b1;
          cnt_q  <= cnt_q - 16'h0001;
        end else if (down_q && cnt_q == 16'h0000) begin
          down_q <= 1'b0;
          cnt_q  <= 16'h0001;
        end else begin
          cnt_q <= down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end
      end
    end
  end

  assign o_count = cnt_q;
  assign o_step  = step_q;
  assign o_down  = down_q;
  assign o_tick  = tick_q;
endmodule // tcp_cnt_model

// File: dv/tcp_timer_assertions.sv
`timescale 1ns/1ps
module tcp_timer_chk #(
  parameter int NCH = 3,
  parameter int CW  = 16
) (
  input wire logic             i_clk,          // Clock
  input wire logic             i_reset,        // Reset
  input wire logic [1:0]       i_timer_mode,   // Mode
  input wire logic [CW-1:0]    i_count,        // Count
  input wire logic             i_count_step,   // Step
  input wire logic             i_count_down,   // Down
  input wire logic [7:0]       i_wr_data,      // Data
  input wire logic [NCH-1:0]   i_cmp_low_wr,   // Low write
  input wire logic [NCH-1:0]   i_cmp_high_wr,  // High write
  input wire logic [3*NCH-1:0] i_chan_cmp_action, // Actions
  input wire logic [NCH-1:0]   i_chan_mode,    // Modes
  input wire logic [NCH-1:0]   i_chan_irq_mask, // Masks
  input wire logic             i_global_timer_irq_enable, // Enable
  input wire logic [NCH-1:0]   o_chan_out,     // Pins
  input wire logic [CW*NCH-1:0] o_chan_cmp_value, // Values
  input wire logic             o_overflow_flag, // Ovf flag
  input wire logic             o_chan0_event_flag, // Flag 0
  input wire logic             o_chan1_event_flag, // Flag 1
  input wire logic             o_irq_req,      // Request
  input wire logic [4:0]       o_irq_vector,   // Vector
  input wire logic             o_dma_trig_chan1, // DMA 1
  input wire logic             o_dsm_active    // Modulator
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire [2:0]  act1 = i_chan_cmp_action[5:3];
  wire [15:0] v0   = o_chan_cmp_value[15:0];
  wire [15:0] v1   = o_chan_cmp_value[31:16];
  wire        hit1 = i_timer_mode != 2'h0 && i_count_step && i_count == v1;

  vec_fixed_a: assert property (o_irq_vector == 5'h09)
    else $error("vector not nine");
  low_held_a: assert property (i_cmp_low_wr[1] && !i_cmp_high_wr[1]
    && act1 <= 3'h2 |=> $stable(v1)) else $error("low byte applied");
  imm_load_a: assert property (i_cmp_high_wr[1] && act1 <= 3'h2
    |=> v1[15:8] == $past(i_wr_data)) else $error("value not loaded");
  ovf_mod_a: assert property (i_timer_mode == 2'h2 && i_count_step
    && i_count == v0 |=> o_overflow_flag) else $error("no overflow");
  ch0_zero_a: assert property (i_timer_mode == 2'h3 && i_count_step
    && i_count == 16'h0000 && i_count_down && i_chan_mode[0]
    |=> o_chan0_event_flag) else $error("no chan0 flag");
  dma1_hit_a: assert property (hit1 && i_chan_mode[1]
    |=> o_dma_trig_chan1) else $error("no dma trigger");
  irq_gate_a: assert property (o_irq_req
    |-> $past(i_global_timer_irq_enable)) else $error("ungated irq");
  remask_a: assert property ($rose(i_chan_irq_mask[1])
    && o_chan1_event_flag && i_global_timer_irq_enable |=> o_irq_req)
    else $error("no irq on mask");
  pin_set_a: assert property (hit1 && act1 == 3'h0 && i_chan_mode[1]
    |-> ##2 o_chan_out[1]) else $error("pin not set");
  dsm_on_a: assert property (o_dsm_active
    == (i_chan_mode[1] && act1 == 3'h7)) else $error("dsm state");
endmodule // tcp_timer_chk

bind tcp_timer tcp_timer_chk #(.NCH(NCH), .CW(CW)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_timer_mode(i_timer_mode),
  .i_count(i_count), .i_count_step(i_count_step),
  .i_count_down(i_count_down), .i_wr_data(i_wr_data),
  .i_cmp_low_wr(i_cmp_low_wr), .i_cmp_high_wr(i_cmp_high_wr),
  .i_chan_cmp_action(i_chan_cmp_action), .i_chan_mode(i_chan_mode),
  .i_chan_irq_mask(i_chan_irq_mask),
  .i_global_timer_irq_enable(i_global_timer_irq_enable),
  .o_chan_out(o_chan_out), .o_chan_cmp_value(o_chan_cmp_value),
  .o_overflow_flag(o_overflow_flag),
  .o_chan0_event_flag(o_chan0_event_flag),
  .o_chan1_event_flag(o_chan1_event_flag), .o_irq_req(o_irq_req),
  .o_irq_vector(o_irq_vector), .o_dma_trig_chan1(o_dma_trig_chan1),
  .o_dsm_active(o_dsm_active));

// File: dv/tcp_timer_tb_top.sv
`timescale 1ns/1ps
module tcp_timer_tb_top;
  logic        i_clk = 0, i_reset = 1, clr = 0, dn, stp, tck;
  logic [1:0]  i_timer_mode = 0, cap = 0;
  logic [7:0]  i_wr_data = 0;
  logic [2:0]  lo_wr = 0, hi_wr = 0, cmode = 0, mask = 0, pins;
  logic [8:0]  act = 0;
  logic [3:0]  fclr = 0;
  logic        gen = 0, cclr = 0, ovf, f0, f1, f2, cpu, irq, dma1, dsm;
  logic [15:0] cnt, per;
  logic [47:0] val;
  logic [4:0]  vec;
  int          n_fail = 0, total_checks = 0, n_irq = 0, n_dma = 0;
  int          n_edge = 0, e0;
  logic        p1 = 0;

  always #4 i_clk = ~i_clk;

  tcp_cnt_model u_cnt (.i_clk(i_clk), .i_reset(i_reset),
    .i_mode(i_timer_mode), .i_period(per), .i_clear(clr),
    .o_count(cnt), .o_step(stp), .o_down(dn), .o_tick(tck));

  tcp_timer u_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_timer_mode(i_timer_mode), .i_count(cnt), .i_count_step(stp),
    .i_count_down(dn), .i_tick(tck), .i_wr_data(i_wr_data),
    .i_cmp_low_wr(lo_wr), .i_cmp_high_wr(hi_wr),
    .i_chan_cmp_action(act), .i_chan_mode(cmode),
    .i_chan_irq_mask(mask), .i_overflow_irq_mask(1'b0),
    .i_capture_sel_field_1(cap), .i_capture_evt(3'h0),
    .i_global_timer_irq_enable(gen), .i_flag_clr(fclr),
    .i_cpu_irq_flag_clr(cclr), .o_chan_out(pins),
    .o_chan_cmp_value(val), .o_period_value(per),
    .o_overflow_flag(ovf), .o_chan0_event_flag(f0),
    .o_chan1_event_flag(f1), .o_chan2_event_flag(f2),
    .o_cpu_timer_irq_flag(cpu), .o_irq_req(irq), .o_irq_vector(vec),
    .o_dma_trig_chan0(), .o_dma_trig_chan1(dma1),
    .o_dma_trig_chan2(), .o_dsm_active(dsm));

  always @(posedge i_clk) begin
    n_irq  += irq;
    n_dma  += dma1;
    n_edge += (pins[1] !== p1);
    p1 = pins[1];
  end

  task automatic chk(logic [47:0] got, logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h, want %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wr(int c, logic [15:0] v);
    @(negedge i_clk) lo_wr[c] = 1; i_wr_data = v[7:0];
    @(negedge i_clk) lo_wr[c] = 0; hi_wr[c] = 1; i_wr_data = v[15:8];
    @(negedge i_clk) hi_wr[c] = 0;
  endtask

  // Bounded wait for a given counter step
  task automatic wait_cnt(logic [15:0] v, logic d);
    int k;
    k = 0;
    while (!(stp && cnt == v && dn == d) && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 400) begin
      n_fail++;
      $display("wrong value at %0t: counter wait ran out", $time);
    end
  endtask

  task automatic t_load();
    wr(1, 16'h1234);
    cyc(1);
    chk(val[31:16], 16'h1234);
    @(negedge i_clk) lo_wr[1] = 1; i_wr_data = 8'hAB;
    @(negedge i_clk) lo_wr[1] = 0;
    cyc(2);
    chk(val[31:16], 16'h1234);
    @(negedge i_clk) hi_wr[1] = 1; i_wr_data = 8'h56;
    @(negedge i_clk) hi_wr[1] = 0;
    chk(val[31:16], 16'h56AB);
    $display("t_load done");
  endtask

  task automatic t_events();
    wr(0, 16'h0013);
    wr(1, 16'h0005);
    cmode = 3'h7;
    gen = 1;
    i_timer_mode = 2'h2;
    wait_cnt(16'h0005, 0);
    cyc(1);
    chk(f1, 1);
    chk(cpu, 0);
    chk(n_irq, 0);
    cyc(1);
    chk(n_dma, 1);
    chk(pins[1], 1);
    wait_cnt(16'h0013, 0);
    cyc(1);
    chk(ovf, 1);
    @(negedge i_clk) mask[1] = 1;
    cyc(2);
    chk(n_irq, 1);
    @(negedge i_clk) fclr = 4'h4; cclr = 1;
    @(negedge i_clk) fclr = 4'h0; cclr = 0;
    chk({f1, cpu}, 0);
    wait_cnt(16'h0005, 0);
    cyc(1);
    chk({cpu, f1}, 2'h3);
    cyc(1);
    chk(n_irq, 2);
    $display("t_events done");
  endtask

  // Chan 0 ignores action 6, so a cleared pin stays low
  task automatic t_ch0();
    act[2:0] = 3'h1;
    wait_cnt(16'h0013, 0);
    cyc(2);
    chk(pins[0], 0);
    act[2:0] = 3'h6;
    wait_cnt(16'h0013, 0);
    cyc(2);
    chk(pins[0], 0);
    $display("t_ch0 done");
  endtask

  task automatic t_defer();
    act[8:6] = 3'h4;
    wait_cnt(16'h0001, 0);
    wr(2, 16'h0009);
    cyc(1);
    chk(val[47:32], 16'h0000);
    wait_cnt(16'h0000, 0);
    cyc(1);
    chk(val[47:32], 16'h0009);
    $display("t_defer done");
  endtask

  task automatic t_updown();
    act[5:3] = 3'h3;
    i_timer_mode = 2'h3;
    @(negedge i_clk) fclr = 4'hF;
    @(negedge i_clk) fclr = 4'h0;
    wait_cnt(16'h0013, 0);
    cyc(2);
    chk(f0, 0);
    wait_cnt(16'h0000, 1);
    cyc(1);
    chk({f0, ovf}, 2'h3);
    chk(pins[1], 0);
    wait_cnt(16'h0006, 0);
    cyc(1);
    chk(pins[1], 1);
    $display("t_updown done");
  endtask

  task automatic t_dsm();
    i_timer_mode = 2'h0;
    @(negedge i_clk) clr = 1;
    @(negedge i_clk) clr = 0;
    wr(0, 16'h0013);
    cmode[0] = 1;
    act[5:3] = 3'h0;
    wr(1, 16'h0000);
    i_timer_mode = 2'h2;
    cmode[1] = 1;
    cap = 2'h1;
    act[5:3] = 3'h7;
    cyc(1);
    chk(dsm, 1);
    e0 = n_edge;
    cyc(320);
    chk((n_edge - e0) >= 30, 1);
    $display("t_dsm done");
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk) i_reset = 0;
    chk(vec, 5'h09);
    chk({pins, f0, f1, f2, ovf, irq}, 0);
    t_load();
    t_events();
    t_ch0();
    t_defer();
    t_updown();
    t_dsm();
    finish_test();
  end
endmodule // tcp_timer_tb_top
